// >>> aorv_regs.svh
// register offsets, field positions and reset values of the analog output routing and volume bank
`ifndef AORV_REGS_SVH
`define AORV_REGS_SVH

`define AORV_MODE1_OFS 8'h04
`define AORV_LINE_VOL_OFS 8'h09
`define AORV_HP_ROUTE_OFS 8'h0D
`define AORV_HP_VOL_OFS 8'h0E
`define AORV_LINE_ROUTE_OFS 8'h0F

`define AORV_LINE_SILENCE_BIT 5
`define AORV_LINE_CODE_MSB 3
`define AORV_HP_CODE_MSB 4
`define AORV_HP_SILENCE_BIT 5
`define AORV_HP_PULLDOWN_BIT 6

`define AORV_LINE_CODE_RST 4'h0
`define AORV_LINE_SILENCE_RST 1'b1
`define AORV_HP_CODE_RST 5'h00
`define AORV_HP_SILENCE_RST 1'b0
`define AORV_HP_PULLDOWN_RST 1'b0
`define AORV_ROUTE_RST 8'h00

`endif

// >>> aorv_pkg.sv
// types shared by the analog output routing and volume bank
`default_nettype none

package aorv_pkg;

  // source index: 0 left in1, 1 right in1, 2 left in2, 3 right in2, 4 left in3, 5 right in3
  localparam int AORV_NUM_SRC = 6;

  typedef struct packed {
    logic [AORV_NUM_SRC-1:0] left_src;
    logic [AORV_NUM_SRC-1:0] right_src;
  } aorv_path_t;

  typedef struct packed {
    logic muted;
    logic [3:0] code;
  } aorv_line_level_t;

  typedef struct packed {
    logic muted;
    logic [4:0] code;
  } aorv_hp_level_t;

endpackage : aorv_pkg

`default_nettype wire

// >>> aorv_vol_apply.sv
// gates a volume code with its mute bit
`timescale 1ns/1ps
`default_nettype none

module aorv_vol_apply #(
  parameter int W = 4
) (
  // setting
  input wire logic [W-1:0] code,
  input wire logic silence,
  // applied value
  output logic [W-1:0] applied_code,
  output logic muted
);

  // the code is forced to zero while muted; the analog side must key on muted, since zero is 0dB on the phone path
  assign applied_code = silence ? '0 : code;
  assign muted = silence;

endmodule : aorv_vol_apply

`default_nettype wire

// >>> aorv_route_map.sv
// expands an eight-bit routing register into per-channel source enables
`timescale 1ns/1ps
`default_nettype none

module aorv_route_map
  import aorv_pkg::*;
(
  // routing register
  input wire logic [7:0] route_bits,
  // expanded enables
  output aorv_path_t path
);

  // even bits feed the left channel, odd bits the right; sources per bit are
  // right in1, left in1, right in2, right in2, left in3, left in3, right in3, right in3
  function automatic int src_of(input int b);
    case (b)
      0: src_of = 1;
      1: src_of = 0;
      2: src_of = 3;
      3: src_of = 3;
      4: src_of = 4;
      5: src_of = 4;
      6: src_of = 5;
      default: src_of = 5;
    endcase
  endfunction : src_of

  function automatic logic [7:0] mask_for(input int k, input int ch);
    logic [7:0] m;
    m = 8'h00;
    for (int b = 0; b < 8; b++) begin
      if ((b % 2) == ch && src_of(b) == k) begin
        m[b] = 1'b1;
      end
    end
    return m;
  endfunction : mask_for

  for (genvar k = 0; k < AORV_NUM_SRC; k++) begin : g_src
    assign path.left_src[k] = |(route_bits & mask_for(k, 0));
    assign path.right_src[k] = |(route_bits & mask_for(k, 1));
  end

endmodule : aorv_route_map

`default_nettype wire

// >>> aorv_top.sv
// analog output routing and volume register bank with registered analog controls
//
// Contract
// - the line-out volume register keeps a four-bit code in its low bits, reads zero above, and resets to 0000 (mute).
// - the line-out volume code is applied only while the line-out mute bit is clear.
// - a set line-out mute bit mutes the line outputs and ignores the code, and that bit resets to one.
// - the headphone routing register has eight independent bits linking one input pin to one phone channel, reset zero.
// - the headphone attenuation register keeps a five-bit code in bits 4..0 reset to 0dB, and bit 7 reads zero.
// - the headphone attenuation code is applied only while the headphone mute bit is clear.
// - headphone mute bit 5 is normal at zero, its reset value, and mutes the amplifier ignoring the code at one.
// - headphone pull-down bit 6 shorts the outputs to ground at zero, its reset value, and selects a weak pull-down at one.
// - the line-out routing register has eight independent bits adding one input pin to a line channel, reset zero.
// - line-out routing offers dedicated cross-coupled paths from left inputs to the right channel and back.
`timescale 1ns/1ps
`default_nettype none
`include "aorv_regs.svh"

module aorv_top
  import aorv_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register port from the serial control interface
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_hit,
  // line output controls
  output aorv_line_level_t line_level,
  output aorv_path_t line_path,
  // headphone controls
  output aorv_hp_level_t hp_level,
  output logic hp_pulldown_select,
  output aorv_path_t hp_path
);

  logic [3:0] lineout_volume_code;
  logic lineout_silence;
  logic [7:0] hp_route;
  logic [4:0] headphone_volume_code;
  logic headphone_silence;
  logic headphone_pulldown_select;
  logic [7:0] line_route;

  logic wr_mode1;
  logic wr_line_vol;
  logic wr_hp_route;
  logic wr_hp_vol;
  logic wr_line_route;

  assign wr_mode1 = reg_wr_en && (reg_addr == `AORV_MODE1_OFS);
  assign wr_line_vol = reg_wr_en && (reg_addr == `AORV_LINE_VOL_OFS);
  assign wr_hp_route = reg_wr_en && (reg_addr == `AORV_HP_ROUTE_OFS);
  assign wr_hp_vol = reg_wr_en && (reg_addr == `AORV_HP_VOL_OFS);
  assign wr_line_route = reg_wr_en && (reg_addr == `AORV_LINE_ROUTE_OFS);

  // only the four code bits are stored; the upper nibble has no flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lineout_volume_code <= `AORV_LINE_CODE_RST;
    end else if (wr_line_vol) begin
      lineout_volume_code <= reg_wdata[`AORV_LINE_CODE_MSB:0];
    end
  end

  // the line mute bit sits in the shared mode register; the other bits there are owned elsewhere
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lineout_silence <= `AORV_LINE_SILENCE_RST;
    end else if (wr_mode1) begin
      lineout_silence <= reg_wdata[`AORV_LINE_SILENCE_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hp_route <= `AORV_ROUTE_RST;
    end else if (wr_hp_route) begin
      hp_route <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      headphone_volume_code <= `AORV_HP_CODE_RST;
      headphone_silence <= `AORV_HP_SILENCE_RST;
      headphone_pulldown_select <= `AORV_HP_PULLDOWN_RST;
    end else if (wr_hp_vol) begin
      headphone_volume_code <= reg_wdata[`AORV_HP_CODE_MSB:0];
      headphone_silence <= reg_wdata[`AORV_HP_SILENCE_BIT];
      headphone_pulldown_select <= reg_wdata[`AORV_HP_PULLDOWN_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      line_route <= `AORV_ROUTE_RST;
    end else if (wr_line_route) begin
      line_route <= reg_wdata;
    end
  end

  // read back: zero-filled fields, unmapped addresses answer zero with no hit
  logic [7:0] next_rdata;
  logic next_hit;

  always_comb begin
    next_rdata = 8'h00;
    next_hit = 1'b1;
    case (reg_addr)
      `AORV_MODE1_OFS: begin
        next_rdata[`AORV_LINE_SILENCE_BIT] = lineout_silence;
      end
      `AORV_LINE_VOL_OFS: begin
        next_rdata = {4'h0, lineout_volume_code};
      end
      `AORV_HP_ROUTE_OFS: begin
        next_rdata = hp_route;
      end
      `AORV_HP_VOL_OFS: begin
        next_rdata = {1'b0, headphone_pulldown_select, headphone_silence, headphone_volume_code};
      end
      `AORV_LINE_ROUTE_OFS: begin
        next_rdata = line_route;
      end
      default: begin
        next_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      reg_rd_hit <= 1'b0;
    end else if (reg_rd_en) begin
      reg_rdata <= next_rdata;
      reg_rd_hit <= next_hit;
    end
  end

  // applied values
  logic [3:0] line_applied;
  logic line_muted;
  logic [4:0] hp_applied;
  logic hp_muted;
  aorv_path_t next_line_path;
  aorv_path_t next_hp_path;

  aorv_vol_apply #(
    .W(4)
  ) u_line_vol (
    .code(lineout_volume_code),
    .silence(lineout_silence),
    .applied_code(line_applied),
    .muted(line_muted)
  );

  aorv_vol_apply #(
    .W(5)
  ) u_hp_vol (
    .code(headphone_volume_code),
    .silence(headphone_silence),
    .applied_code(hp_applied),
    .muted(hp_muted)
  );

  aorv_route_map u_line_map (
    .route_bits(line_route),
    .path(next_line_path)
  );

  aorv_route_map u_hp_map (
    .route_bits(hp_route),
    .path(next_hp_path)
  );

  // outputs are re-registered so the analog switches see glitch-free levels, at one cycle of extra latency
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      line_level <= '{muted: 1'b1, code: 4'h0};
    end else begin
      line_level <= '{muted: line_muted, code: line_applied};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hp_level <= '{muted: 1'b0, code: 5'h00};
      hp_pulldown_select <= 1'b0;
    end else begin
      hp_level <= '{muted: hp_muted, code: hp_applied};
      hp_pulldown_select <= headphone_pulldown_select;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      line_path <= '0;
      hp_path <= '0;
    end else begin
      line_path <= next_line_path;
      hp_path <= next_hp_path;
    end
  end

  // checks
  logic quiet_line_next;
  assign quiet_line_next = !(reg_wr_en && (reg_addr == `AORV_LINE_VOL_OFS || reg_addr == `AORV_MODE1_OFS));

  chk_line_reset_mute: assert property (@(posedge core_clk)
    (resetn && !$past(resetn)) |-> (lineout_silence && lineout_volume_code == 4'h0 && line_level.muted))
    else $error("line output not muted after reset");

  chk_line_code_apply: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_line_vol && !lineout_silence) ##1 quiet_line_next |->
      ##1 (!line_level.muted && line_level.code == $past(reg_wdata[3:0], 2)))
    else $error("line volume code not applied while unmuted");

  chk_line_mute_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    lineout_silence |=> (line_level.muted && line_level.code == 4'h0))
    else $error("line volume code leaked through mute");

  chk_line_upper_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    (reg_rd_en && reg_addr == `AORV_LINE_VOL_OFS) |=> (reg_rdata[7:4] == 4'h0 && reg_rd_hit))
    else $error("line volume upper nibble not zero");

  chk_hp_code_apply: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_hp_vol && !reg_wdata[5]) ##1 !wr_hp_vol |->
      ##1 (hp_level.code == $past(reg_wdata[4:0], 2) && !hp_level.muted))
    else $error("headphone code not applied while unmuted");

  chk_hp_mute_ignore: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_hp_vol && reg_wdata[5]) ##1 !wr_hp_vol |-> ##1 (hp_level.muted && hp_level.code == 5'h00))
    else $error("headphone mute did not ignore code");

  chk_hp_pulldown_sel: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_hp_vol ##1 !wr_hp_vol |-> ##1 (hp_pulldown_select == $past(reg_wdata[6], 2)))
    else $error("headphone pull-down select mismatch");

  chk_hp_bit7_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    (reg_rd_en && reg_addr == `AORV_HP_VOL_OFS) |=> (reg_rdata[7] == 1'b0))
    else $error("headphone attenuation bit 7 not zero");

  // the host leaves one idle cycle between a write and the next read, so the echo is judged three edges on
  chk_hp_route_echo: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_hp_route ##1 !reg_wr_en ##1 (reg_rd_en && reg_addr == `AORV_HP_ROUTE_OFS && !reg_wr_en) |=>
      (reg_rdata == $past(reg_wdata, 3)))
    else $error("headphone routing read back mismatch");

  chk_line_cross_path: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_line_route ##1 !wr_line_route |->
      ##1 (line_path.left_src[1] == $past(reg_wdata[0], 2) && line_path.right_src[0] == $past(reg_wdata[1], 2)))
    else $error("line cross-coupled path mismatch");

  chk_line_route_bits: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_line_route ##1 !wr_line_route |->
      ##1 (line_path.left_src[4] == $past(reg_wdata[4], 2) && line_path.right_src[5] == $past(reg_wdata[7], 2)))
    else $error("line routing bit mismatch");

  chk_unmapped_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    (reg_rd_en && !next_hit) |=> (!reg_rd_hit && reg_rdata == 8'h00))
    else $error("unmapped read not zero");

  chk_hp_reset_state: assert property (@(posedge core_clk)
    (resetn && !$past(resetn)) |->
      (!headphone_silence && !headphone_pulldown_select && headphone_volume_code == 5'h00 &&
       hp_route == 8'h00 && line_route == 8'h00))
    else $error("headphone or routing state not cleared after reset");

  chk_hp_cross_path: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_hp_route ##1 !wr_hp_route |->
      ##1 (hp_path.left_src[1] == $past(reg_wdata[0], 2) && hp_path.right_src[5] == $past(reg_wdata[7], 2)))
    else $error("headphone routing bit mismatch");

  chk_line_vol_store: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_line_vol |=> (lineout_volume_code == $past(reg_wdata[3:0])))
    else $error("line volume code not stored");

  chk_hp_mute_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    headphone_silence |=> (hp_level.muted && hp_level.code == 5'h00))
    else $error("headphone code leaked through mute");

  // only the line mute bit of the shared mode register belongs here; the rest must read zero
  chk_mode_read_bit: assert property (@(posedge core_clk) disable iff (!resetn)
    (reg_rd_en && reg_addr == `AORV_MODE1_OFS) |=>
      (reg_rdata[7:6] == 2'h0 && reg_rdata[5] == $past(lineout_silence) && reg_rdata[4:0] == 5'h00))
    else $error("mode register read back mismatch");

  cov_line_unmuted: cover property (@(posedge core_clk) disable iff (!resetn)
    (!line_level.muted && line_level.code != 4'h0));

  cov_hp_muted: cover property (@(posedge core_clk) disable iff (!resetn)
    (hp_level.muted && hp_pulldown_select));

  cov_cross_couple: cover property (@(posedge core_clk) disable iff (!resetn)
    (line_path.left_src[1] && line_path.right_src[0]));

  cov_unmapped_read: cover property (@(posedge core_clk) disable iff (!resetn)
    (reg_rd_en && !next_hit));

  cov_hp_route_read: cover property (@(posedge core_clk) disable iff (!resetn)
    (reg_rd_en && reg_addr == `AORV_HP_ROUTE_OFS && hp_route != 8'h00));

endmodule : aorv_top

`default_nettype wire

// >>> aorv_host_model.sv
// host side model that issues register writes and reads on the register port
`timescale 1ns/1ps
`default_nettype none

module aorv_host_model (
  // clock and returned data
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_hit,
  // register port strobes
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // strobes move on the falling edge so the rising edge sees stable values
  task bus_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    // stale data is not left standing on the bus
    reg_wdata = ~d;
  endtask : bus_write

  task bus_read(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    d = reg_rdata;
    h = reg_rd_hit;
  endtask : bus_read
endmodule : aorv_host_model

`default_nettype wire

// >>> tb.sv
// self-checking testbench for the analog output routing and volume bank
`timescale 1ns/1ps
`default_nettype none
`include "aorv_regs.svh"

module tb
  import aorv_pkg::*;
;
  logic core_clk;
  logic resetn;
  wire logic reg_wr_en;
  wire logic reg_rd_en;
  wire logic [7:0] reg_addr;
  wire logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rd_hit;
  aorv_line_level_t line_level;
  aorv_path_t line_path;
  aorv_hp_level_t hp_level;
  logic hp_pulldown_select;
  aorv_path_t hp_path;
  int error_cnt = 0;
  int n_tests = 0;

  aorv_top dut_u (.core_clk(core_clk), .resetn(resetn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_hit(reg_rd_hit),
    .line_level(line_level), .line_path(line_path), .hp_level(hp_level),
    .hp_pulldown_select(hp_pulldown_select), .hp_path(hp_path));

  aorv_host_model host_u (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_rd_hit(reg_rd_hit),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task report_and_stop();
    $display("tests %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  task check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task rd_check(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    logic [7:0] d;
    logic h;
    host_u.bus_read(a, d, h);
    check("read data", {8'h00, exp}, {8'h00, d});
    check("read hit", {15'h0000, hit}, {15'h0000, h});
  endtask : rd_check

  // routing bit map shared by both routing registers
  function automatic aorv_path_t exp_path(input logic [7:0] b);
    aorv_path_t p;
    p = '0;
    p.left_src[1] = b[0];
    p.right_src[0] = b[1];
    p.left_src[3] = b[2];
    p.right_src[3] = b[3];
    p.left_src[4] = b[4];
    p.right_src[4] = b[5];
    p.left_src[5] = b[6];
    p.right_src[5] = b[7];
    return p;
  endfunction : exp_path

  // outputs follow one edge after the register takes the write
  task wr_settle(input logic [7:0] a, input logic [7:0] d);
    host_u.bus_write(a, d);
    @(negedge core_clk);
  endtask : wr_settle

  task test_reset();
    check("line level", 16'h0010, {11'h000, line_level});
    check("hp level", 16'h0000, {10'h000, hp_level});
    check("pulldown", 16'h0000, {15'h0000, hp_pulldown_select});
    check("line path", 16'h0000, {4'h0, line_path});
    check("hp path", 16'h0000, {4'h0, hp_path});
    rd_check(`AORV_MODE1_OFS, 8'h20, 1'b1);
    rd_check(`AORV_LINE_VOL_OFS, 8'h00, 1'b1);
    rd_check(`AORV_HP_ROUTE_OFS, 8'h00, 1'b1);
    rd_check(`AORV_HP_VOL_OFS, 8'h00, 1'b1);
    rd_check(`AORV_LINE_ROUTE_OFS, 8'h00, 1'b1);
    $display("test_reset done");
  endtask : test_reset

  task test_line_vol();
    wr_settle(`AORV_LINE_VOL_OFS, 8'hFA);
    rd_check(`AORV_LINE_VOL_OFS, 8'h0A, 1'b1);
    check("line level muted", 16'h0010, {11'h000, line_level});
    wr_settle(`AORV_MODE1_OFS, 8'h00);
    check("line level open", 16'h000A, {11'h000, line_level});
    wr_settle(`AORV_LINE_VOL_OFS, 8'hC6);
    check("line level new code", 16'h0006, {11'h000, line_level});
    rd_check(`AORV_LINE_VOL_OFS, 8'h06, 1'b1);
    wr_settle(`AORV_MODE1_OFS, 8'hFF);
    rd_check(`AORV_MODE1_OFS, 8'h20, 1'b1);
    check("line level remuted", 16'h0010, {11'h000, line_level});
    $display("test_line_vol done");
  endtask : test_line_vol

  task test_hp_vol();
    wr_settle(`AORV_HP_VOL_OFS, 8'hFF);
    rd_check(`AORV_HP_VOL_OFS, 8'h7F, 1'b1);
    check("hp level muted", 16'h0020, {10'h000, hp_level});
    check("pulldown weak", 16'h0001, {15'h0000, hp_pulldown_select});
    wr_settle(`AORV_HP_VOL_OFS, 8'h13);
    check("hp level open", 16'h0013, {10'h000, hp_level});
    check("pulldown short", 16'h0000, {15'h0000, hp_pulldown_select});
    $display("test_hp_vol done");
  endtask : test_hp_vol

  task test_routes();
    logic [7:0] b;
    for (int i = 0; i < 8; i++) begin
      b = 8'h01 << i;
      host_u.bus_write(`AORV_HP_ROUTE_OFS, b);
      rd_check(`AORV_HP_ROUTE_OFS, b, 1'b1);
      wr_settle(`AORV_LINE_ROUTE_OFS, ~b);
      check("hp path", {4'h0, exp_path(b)}, {4'h0, hp_path});
      check("line path", {4'h0, exp_path(~b)}, {4'h0, line_path});
      rd_check(`AORV_LINE_ROUTE_OFS, ~b, 1'b1);
    end
    $display("test_routes done");
  endtask : test_routes

  task test_unmapped();
    wr_settle(8'h10, 8'hFF);
    rd_check(8'h10, 8'h00, 1'b0);
    rd_check(`AORV_LINE_VOL_OFS, 8'h06, 1'b1);
    $display("test_unmapped done");
  endtask : test_unmapped

  initial begin
    resetn = 1'b0;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    test_reset();
    test_line_vol();
    test_hp_vol();
    test_routes();
    test_unmapped();
    report_and_stop();
  end

  // a hung run is cut short and counted as a mismatch
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
